// ### ecap_ctrl.sv
// two-channel edge capture timer control with apb register access
// Operation
// - reload high holds interval bits 11:8 in bits 3:0; upper bits read zero
// - first-edge-hold bit 7 governs all four capture registers alike
// - hold clear: every qualifying edge overwrites its capture register
// - hold set: first edge kept, later edges ignored until register read
// - prescale bits 6:4 value n captures timer bits 7+n down to n, except in wide mode
// - config bit 3 stops channel 1 captures (its status bits still set), its registers extend channel 0
// - enable bits 3:0: ch1 fall, ch1 rise, ch0 fall, ch0 rise
// - status bit 3 on channel 1 falling edge, bit 2 on rising
// - status bit 1 on channel 0 falling edge, bit 0 on rising
// - each edge stores timer value in matching rise or fall register
// - wide mode: ch0 edge loads low byte ch0, high byte ch1 register
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ecap_cfg.svh"

module ecap_ctrl #(
    parameter int TMR_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ECAP_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [TMR_W-1:0] timer_value,
    input wire logic capture_input_zero,
    input wire logic capture_input_one,
    output logic [3:0] interval_reload_high,
    output logic capture_irq
);

    ////////////////////////////////////////////////////////////////
    function automatic logic [`ECAP_IDX_W-1:0] ecap_idx(
        input logic [`ECAP_AW-1:0] a
    );
        return a[`ECAP_AW-1:2];
    endfunction

    function automatic logic ecap_hit(input logic [`ECAP_AW-1:0] a);
        logic [`ECAP_IDX_W-1:0] i;
        i = a[`ECAP_AW-1:2];
        if (a[1:0] != 2'h0) begin
            return 1'b0;
        end
        return (i >= `ECAP_IDX_CAP0R && i <= `ECAP_IDX_CAP1F)
            || (i >= `ECAP_IDX_RLDH && i <= `ECAP_IDX_ST);
    endfunction

    function automatic logic [7:0] ecap_slice(
        input logic [TMR_W-1:0] t,
        input logic [2:0] n
    );
        logic [TMR_W-1:0] s;
        s = t >> n;
        return s[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////
    ecap_pkg::ecap_state_t q;
    ecap_pkg::ecap_state_t d;
    logic rise0;
    logic fall0;
    logic rise1;
    logic fall1;
    logic [3:0] ev;
    logic [`ECAP_IDX_W-1:0] idx;
    logic hit;
    logic setup;
    logic wr;
    logic rd;
    logic feh;
    logic wide;
    logic [2:0] presc;
    logic [7:0] slice;
    logic [1:0] ci;

    ecap_edge_sync u_sync0 (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin(capture_input_zero),
        .rise(rise0),
        .fall(fall0)
    );

    ecap_edge_sync u_sync1 (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin(capture_input_one),
        .rise(rise1),
        .fall(fall1)
    );

    assign ev = {fall1, rise1, fall0, rise0};
    assign idx = ecap_idx(paddr);
    assign hit = ecap_hit(paddr);
    assign setup = psel & ~penable;
    assign wr = clk_en & psel & penable & pwrite & hit;
    assign rd = clk_en & psel & penable & ~pwrite & hit;
    assign feh = q.cfg[`ECAP_CFG_FEH];
    assign wide = q.cfg[`ECAP_CFG_WIDE];
    assign presc = q.cfg[`ECAP_CFG_PS_HI:`ECAP_CFG_PS_LO];
    assign slice = ecap_slice(timer_value, presc);
    assign ci = idx[1:0] - 2'h2;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        if (clk_en) begin
            // read data registered in setup, so zero wait states
            if (setup) begin
                d.rdata = 32'h0000_0000;
                case (idx)
                    `ECAP_IDX_CAP0R: d.rdata[7:0] = q.cap[0];
                    `ECAP_IDX_CAP1R: d.rdata[7:0] = q.cap[1];
                    `ECAP_IDX_CAP0F: d.rdata[7:0] = q.cap[2];
                    `ECAP_IDX_CAP1F: d.rdata[7:0] = q.cap[3];
                    `ECAP_IDX_RLDH: d.rdata[3:0] = q.rld_hi;
                    `ECAP_IDX_CFG: d.rdata[7:0] = q.cfg;
                    `ECAP_IDX_IE: d.rdata[3:0] = q.ie;
                    `ECAP_IDX_ST: d.rdata[3:0] = q.st;
                    default: d.rdata = 32'h0000_0000;
                endcase
            end
            if (wr) begin
                case (idx)
                    `ECAP_IDX_CAP0R: d.cap[0] = pwdata[7:0];
                    `ECAP_IDX_CAP1R: d.cap[1] = pwdata[7:0];
                    `ECAP_IDX_CAP0F: d.cap[2] = pwdata[7:0];
                    `ECAP_IDX_CAP1F: d.cap[3] = pwdata[7:0];
                    `ECAP_IDX_RLDH: d.rld_hi = pwdata[3:0];
                    `ECAP_IDX_CFG: d.cfg = {pwdata[7:3], 3'h0};
                    `ECAP_IDX_IE: d.ie = pwdata[3:0];
                    // write one to clear
                    `ECAP_IDX_ST: d.st = q.st & ~pwdata[3:0];
                    default: d.cfg = q.cfg;
                endcase
            end
            // a read of a capture register re-arms it
            if (rd && idx >= `ECAP_IDX_CAP0R && idx <= `ECAP_IDX_CAP1F) begin
                d.held[ci] = 1'b0;
            end
            // edges beat software writes in the same cycle
            if (wide) begin
                if (rise0 && !(feh && q.held[0])) begin
                    d.cap[0] = timer_value[7:0];
                    d.cap[1] = timer_value[15:8];
                    d.held[0] = 1'b1;
                end
                if (fall0 && !(feh && q.held[2])) begin
                    d.cap[2] = timer_value[7:0];
                    d.cap[3] = timer_value[15:8];
                    d.held[2] = 1'b1;
                end
            end else begin
                // hold clear lets every edge overwrite
                if (rise0 && !(feh && q.held[0])) begin
                    d.cap[0] = slice;
                    d.held[0] = 1'b1;
                end
                if (fall0 && !(feh && q.held[2])) begin
                    d.cap[2] = slice;
                    d.held[2] = 1'b1;
                end
                if (rise1 && !(feh && q.held[1])) begin
                    d.cap[1] = slice;
                    d.held[1] = 1'b1;
                end
                if (fall1 && !(feh && q.held[3])) begin
                    d.cap[3] = slice;
                    d.held[3] = 1'b1;
                end
            end
            // set wins over a clear in the same cycle
            d.st = d.st | ev;
            d.irq = |(d.st & d.ie);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.rld_hi <= `ECAP_RST_RLDH;
            q.cfg <= `ECAP_RST_CFG;
            q.ie <= `ECAP_RST_IE;
            q.st <= `ECAP_RST_ST;
            q.cap <= {4{`ECAP_RST_CAP}};
            q.held <= 4'h0;
            q.rdata <= 32'h0000_0000;
            q.irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus stalls while the block is frozen
    assign pready = clk_en;
    assign pslverr = psel & penable & ~hit;
    assign prdata = q.rdata;
    assign interval_reload_high = q.rld_hi;
    assign capture_irq = q.irq;

    ////////////////////////////////////////////////////////////////
    logic [7:0] tmr_lo;
    logic [7:0] tmr_hi;
    logic bus_wr_any;
    assign tmr_lo = timer_value[7:0];
    assign tmr_hi = timer_value[15:8];
    assign bus_wr_any = psel & penable & pwrite;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    rld_rsv_zero_a: assert property (
        clk_en && setup && paddr == {`ECAP_IDX_RLDH, 2'h0}
        |=> prdata[31:4] == 28'h0 && prdata[3:0] == q.rld_hi)
        else $error("reload high reserved bits not zero");

    hold_keeps_value_a: assert property (
        clk_en && feh && q.held[3] && fall1 && !wide && !bus_wr_any
        |=> $stable(q.cap[3]))
        else $error("held capture overwritten by later edge");

    latest_edge_wins_a: assert property (
        clk_en && !feh && !wide && rise0
        |=> q.cap[0] == $past(slice) && q.held[0])
        else $error("edge did not overwrite capture");

    prescale_slice_a: assert property (
        clk_en && !feh && !wide && fall1
        |=> q.cap[3] == $past(slice))
        else $error("captured slice does not follow prescale");

    ch1_disabled_a: assert property (
        clk_en && wide && rise1 && !rise0 && !bus_wr_any
        |=> $stable(q.cap[1]))
        else $error("channel one captured in wide mode");

    wide_split_a: assert property (
        clk_en && wide && !feh && fall0
        |=> q.cap[2] == $past(tmr_lo) && q.cap[3] == $past(tmr_hi))
        else $error("wide capture bytes misplaced");

    ch1_status_a: assert property (
        clk_en && fall1 |=> q.st[3] ##1 (q.st[3] || $past(wr)))
        else $error("channel one fall flag lost");

    ch0_status_a: assert property (
        clk_en && rise0 && wr && idx == `ECAP_IDX_ST
        |=> q.st[0])
        else $error("channel zero rise flag lost to clear");

    irq_follows_a: assert property (
        capture_irq == |(q.st & q.ie))
        else $error("interrupt request not status and enable");

    irq_on_edge_a: assert property (
        clk_en && |(ev & q.ie) && !bus_wr_any
        |=> capture_irq)
        else $error("enabled edge raised no interrupt request");

    hold_release_a: assert property (
        rd && idx == `ECAP_IDX_CAP1R && !rise1 |=> !q.held[1])
        else $error("read did not re-arm capture");

    wide_edge_c: cover property (clk_en && wide && rise0);
    hold_ignore_c: cover property (clk_en && feh && q.held[0] && rise0);
    irq_raise_c: cover property (!capture_irq ##1 capture_irq);
    status_clear_c: cover property (wr && idx == `ECAP_IDX_ST && |q.st);

endmodule

`default_nettype wire

// ### ecap_cfg.svh
// register indices, field positions and reset values of the capture timer control
`ifndef ECAP_CFG_SVH
`define ECAP_CFG_SVH

`define ECAP_AW 8
`define ECAP_IDX_W 6
`define ECAP_IDX_CAP0R 6'h22
`define ECAP_IDX_CAP1R 6'h23
`define ECAP_IDX_CAP0F 6'h24
`define ECAP_IDX_CAP1F 6'h25
`define ECAP_IDX_RLDH 6'h29
`define ECAP_IDX_CFG 6'h2A
`define ECAP_IDX_IE 6'h2B
`define ECAP_IDX_ST 6'h2C

`define ECAP_CFG_FEH 7
`define ECAP_CFG_PS_HI 6
`define ECAP_CFG_PS_LO 4
`define ECAP_CFG_WIDE 3

`define ECAP_RST_RLDH 4'h0
`define ECAP_RST_CFG 8'h00
`define ECAP_RST_IE 4'h0
`define ECAP_RST_ST 4'h0
`define ECAP_RST_CAP 8'h00

`endif

// ### ecap_pkg.sv
// types shared by the capture timer control and its edge synchroniser
package ecap_pkg;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ecap_sync_t;

    // cap index: 0 ch0 rise, 1 ch1 rise, 2 ch0 fall, 3 ch1 fall
    typedef struct packed {
        logic [3:0] rld_hi;
        logic [7:0] cfg;
        logic [3:0] ie;
        logic [3:0] st;
        logic [3:0][7:0] cap;
        logic [3:0] held;
        logic [31:0] rdata;
        logic irq;
    } ecap_state_t;

endpackage

// ### ecap_edge_sync.sv
// two-flop synchroniser and edge detector for one capture input
`timescale 1ns/10ps
`default_nettype none

module ecap_edge_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic pin,
    output logic rise,
    output logic fall
);

    ecap_pkg::ecap_sync_t q;
    ecap_pkg::ecap_sync_t d;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        if (clk_en) begin
            d.s1 = pin;
            // s1 feeds only s2
            d.s2 = q.s1;
            d.s3 = q.s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pulses last one enabled cycle
    assign rise = clk_en & q.s2 & ~q.s3;
    assign fall = clk_en & ~q.s2 & q.s3;

endmodule

`default_nettype wire

// ### ecap_src.sv
// edge source model for the two capture inputs
`timescale 1ns/10ps
`default_nettype none

module ecap_src (
    input wire logic pclk,
    input wire logic [1:0] lvl,
    output logic pin0,
    output logic pin1
);
    // levels move only just after a clock edge; the pulse task holds each level 6 cycles
    initial begin
        pin0 = 1'b0;
        pin1 = 1'b0;
    end
    always @(posedge pclk) begin
        pin0 <= lvl[0];
        pin1 <= lvl[1];
    end
endmodule

`default_nettype wire

// ### edge_capture_timer_control_tb_top.sv
// self-checking bench for the capture timer control
`timescale 1ns/10ps
`default_nettype none
`include "ecap_cfg.svh"

module edge_capture_timer_control_tb_top;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] exp;
    } ecap_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, pin0, pin1, capture_irq, err;
    logic [15:0] tmr = 16'h0000;
    logic [1:0] lvl = 2'b00;
    logic clk_en = 1'b1;
    logic [3:0] rld_hi;
    int num_errors = 0;
    int n_compared = 0;
    ecap_row_t rows [8];

    always #50 pclk = ~pclk;

    ecap_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_value(tmr),
        .capture_input_zero(pin0), .capture_input_one(pin1),
        .interval_reload_high(rld_hi), .capture_irq(capture_irq));
    ecap_src src (.pclk(pclk), .lvl(lvl), .pin0(pin0), .pin1(pin1));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // idle edge first, so a release is never overwritten in the same step
    task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            num_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [5:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(rd, {24'h000000, e});
    endtask

    // timer held steady while the pins toggle, so every capture is predictable
    task automatic pulse(input logic [1:0] m, input logic [15:0] t);
        tmr <= t;
        lvl <= m;
        repeat (6) @(posedge pclk);
        lvl <= 2'b00;
        repeat (6) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{8'h00, 8'h3C}, '{8'h10, 8'h1E}, '{8'h20, 8'h8F}, '{8'h30, 8'h47},
                 '{8'h40, 8'hA3}, '{8'h50, 8'hD1}, '{8'h60, 8'h68}, '{8'h70, 8'hB4}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`ECAP_IDX_RLDH, 8'h00);
        rdchk(`ECAP_IDX_CFG, 8'h00);
        rdchk(`ECAP_IDX_IE, 8'h00);
        rdchk(`ECAP_IDX_ST, 8'h00);
        chk({31'h0, capture_irq}, 32'h0);
        // low reload byte lives outside, so only the nibble is written here
        apb(1'b1, `ECAP_IDX_RLDH, 8'hFF);
        rdchk(`ECAP_IDX_RLDH, 8'h0F);
        chk({28'h0, rld_hi}, 32'hF);
        $display("reset and reload test done");
        foreach (rows[r]) begin
            apb(1'b1, `ECAP_IDX_CFG, rows[r].cfg);
            pulse(2'b11, 16'h5A3C);
            rdchk(`ECAP_IDX_CAP0R, rows[r].exp);
            rdchk(`ECAP_IDX_CAP1R, rows[r].exp);
            rdchk(`ECAP_IDX_CAP0F, rows[r].exp);
            rdchk(`ECAP_IDX_CAP1F, rows[r].exp);
            rdchk(`ECAP_IDX_ST, 8'h0F);
            apb(1'b1, `ECAP_IDX_ST, 8'h0F);
        end
        $display("prescale table test done");
        apb(1'b1, `ECAP_IDX_CFG, 8'h80);
        pulse(2'b11, 16'h0011);
        pulse(2'b11, 16'h0022);
        rdchk(`ECAP_IDX_CAP0R, 8'h11);
        rdchk(`ECAP_IDX_CAP1F, 8'h11);
        pulse(2'b11, 16'h0033);
        rdchk(`ECAP_IDX_CAP0R, 8'h33);
        rdchk(`ECAP_IDX_CAP1F, 8'h33);
        rdchk(`ECAP_IDX_CAP1R, 8'h11);
        rdchk(`ECAP_IDX_CAP0F, 8'h11);
        apb(1'b1, `ECAP_IDX_CFG, 8'h00);
        pulse(2'b11, 16'h0044);
        pulse(2'b11, 16'h0055);
        rdchk(`ECAP_IDX_CAP0R, 8'h55);
        rdchk(`ECAP_IDX_CAP1F, 8'h55);
        $display("edge hold test done");
        apb(1'b1, `ECAP_IDX_ST, 8'h0F);
        apb(1'b1, `ECAP_IDX_CFG, 8'h0F);
        rdchk(`ECAP_IDX_CFG, 8'h08);
        pulse(2'b01, 16'hBEEF);
        pulse(2'b10, 16'h0101);
        rdchk(`ECAP_IDX_CAP0R, 8'hEF);
        rdchk(`ECAP_IDX_CAP1R, 8'hBE);
        rdchk(`ECAP_IDX_CAP0F, 8'hEF);
        rdchk(`ECAP_IDX_CAP1F, 8'hBE);
        rdchk(`ECAP_IDX_ST, 8'h0F);
        $display("wide mode test done");
        apb(1'b1, `ECAP_IDX_CFG, 8'h00);
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, `ECAP_IDX_ST, 8'h0F);
            apb(1'b1, `ECAP_IDX_IE, 8'h01 << b);
            rdchk(`ECAP_IDX_IE, 8'h01 << b);
            chk({31'h0, capture_irq}, 32'h0);
            pulse(2'b01, 16'h0000);
            rdchk(`ECAP_IDX_ST, 8'h03);
            chk({31'h0, capture_irq}, {31'h0, b < 2});
        end
        apb(1'b1, `ECAP_IDX_IE, 8'h00);
        @(posedge pclk);
        chk({31'h0, capture_irq}, 32'h0);
        $display("interrupt test done");
        // clear lands on the very edge that sets bit 0: the set must win
        lvl <= 2'b01;
        @(posedge pclk);
        apb(1'b1, `ECAP_IDX_ST, 8'h0F);
        rdchk(`ECAP_IDX_ST, 8'h01);
        lvl <= 2'b00;
        repeat (6) @(posedge pclk);
        apb(1'b1, `ECAP_IDX_ST, 8'h0F);
        // frozen block must not see a pulse that ends before it wakes
        clk_en <= 1'b0;
        pulse(2'b11, 16'h00FF);
        chk({31'h0, pready}, 32'h0);
        clk_en <= 1'b1;
        rdchk(`ECAP_IDX_ST, 8'h00);
        $display("set priority and freeze test done");
        apb(1'b0, 6'h30, 8'h00);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("unmapped access test done");
        apb(1'b1, `ECAP_IDX_IE, 8'h0F);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, capture_irq}, 32'h0);
        presetn <= 1'b1;
        rdchk(`ECAP_IDX_IE, 8'h00);
        rdchk(`ECAP_IDX_RLDH, 8'h00);
        chk({28'h0, rld_hi}, 32'h0);
        $display("mid-run reset test done");
        summarize();
    end
endmodule

`default_nettype wire
